// >>> hdl/tpo_tx_path_overhead.sv
`timescale 1ns/1ps
module tpo_tx_path_overhead
  import tpo_pkg::*;
#(
  parameter int FRAME_BITS = 32,
  parameter int CLK_DIV    = BIT_CLK_DIV
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             overhead_bit_clock,
  output logic             overhead_slot_valid,
  output logic             overhead_frame_marker,
  output logic             overhead_insert_request,
  input  wire logic        overhead_serial_in,
  output logic             envelope_strobe,
  output logic      [7:0]  trace_byte_out,
  output logic      [7:0]  signal_label_out
);

  localparam int DW = $clog2(CLK_DIV);
  localparam int PW = $clog2(FRAME_BITS);
  localparam logic [DW-1:0] DIV_LAST = DW'(CLK_DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(CLK_DIV / 2);
  localparam logic [PW-1:0] POS_LAST = PW'(FRAME_BITS - 1);

  generate
    if (FRAME_BITS <= C2_LAST_POS + 1 || CLK_DIV < 4 || (CLK_DIV % 2) != 0) begin : g_bad
      $error("tpo_tx_path_overhead: frame too short or bit clock divider unusable");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]          path_ctl_reg;
  logic [7:0]          trace_val_reg;
  logic [7:0]          label_val_reg;
  logic [7:0]          trace_ctl_reg;
  logic [7:0]          rdata_reg;
  logic [7:0]          trace_buf [TRACE_BUF_DEPTH];
  logic [DW-1:0]       div_reg;
  logic [PW-1:0]       pos_reg;
  logic                bclk_reg;
  logic                slot_reg;
  logic                marker_reg;
  logic                insert_reg;
  logic                rise_d1_reg;
  logic                rise_d2_reg;
  logic                cap_d_reg;
  logic                ser_s1_reg;
  logic                ser_s2_reg;
  logic [7:0]          j1_serial_reg;
  logic [7:0]          c2_serial_reg;
  logic [TRACE_BUF_AW-1:0] msg_idx_reg;
  logic                strobe_reg;
  logic [7:0]          trace_out_reg;
  logic [7:0]          label_out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  tpo_trace_src_type   trace_src;
  logic                label_src_serial;
  logic [1:0]          msg_size;
  logic [6:0]          msg_len;
  logic [DW-1:0]       div_next;
  logic [PW-1:0]       pos_next;
  logic                rise_evt;
  logic                fall_evt;
  logic                env_evt;
  logic                cap_evt;
  logic                in_j1;
  logic                in_c2;
  logic [7:0]          shift_byte;
  logic [7:0]          buf_rd;
  logic [7:0]          j1_sel;
  logic [7:0]          c2_sel;
  logic [TRACE_BUF_AW-1:0] msg_idx_next;
  logic                hit_ctl;
  logic                hit_tval;
  logic                hit_lval;
  logic                hit_tctl;
  logic                hit_buf;
  logic [7:0]          rd_mux;

  assign trace_src        = tpo_trace_src_type'(trace_ctl_reg[TCTL_SRC_LSB +: 2]);
  assign label_src_serial = path_ctl_reg[CTL_LABEL_SRC_BIT];
  assign msg_size         = trace_ctl_reg[TCTL_LEN_LSB +: 2];
  assign msg_len = (msg_size == 2'h0) ? 7'(MSG_LEN_SHORT) :
                   (msg_size == 2'h1) ? 7'(MSG_LEN_MID) : 7'(MSG_LEN_LONG);

  // Bit clock is derived here, so the pin-side logic needs no second domain.
  assign rise_evt = (div_reg == DIV_LAST);
  assign fall_evt = (div_reg == DIV_HALF - DW'(1));
  assign div_next = rise_evt ? '0 : div_reg + DW'(1);
  assign pos_next = (pos_reg == POS_LAST) ? '0 : pos_reg + PW'(1);
  assign env_evt  = fall_evt && (pos_reg == POS_LAST);

  // Capture waits for the synchroniser, well before the next falling edge.
  assign cap_evt = rise_d2_reg;
  assign in_j1   = (pos_reg >= PW'(J1_FIRST_POS)) && (pos_reg <= PW'(J1_LAST_POS));
  assign in_c2   = (pos_reg >= PW'(C2_FIRST_POS)) && (pos_reg <= PW'(C2_LAST_POS));

  tpo_shift_in #(
    .WIDTH (BYTE_BITS)
  ) u_shift (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .shift_en (cap_evt && (in_j1 || in_c2)),
    .bit_in   (ser_s2_reg),
    .data_out (shift_byte)
  );

  assign buf_rd = trace_buf[msg_idx_reg];
  assign j1_sel = (trace_src == TPO_SRC_ZERO)   ? BYTE_ZERO :
                  (trace_src == TPO_SRC_BUFFER) ? buf_rd :
                  (trace_src == TPO_SRC_VALUE)  ? trace_val_reg :
                                                  j1_serial_reg;
  assign c2_sel = label_src_serial ? c2_serial_reg : label_val_reg;
  assign msg_idx_next = (7'(msg_idx_reg) + 7'd1 >= msg_len) ? '0 :
                        msg_idx_reg + TRACE_BUF_AW'(1);

  ////////////////////////////////////////////////////////////////////////////////
  assign hit_ctl  = (reg_addr == ADDR_PATH_CTL);
  assign hit_tval = (reg_addr == ADDR_TRACE_VAL);
  assign hit_lval = (reg_addr == ADDR_LABEL_VAL);
  assign hit_tctl = (reg_addr == ADDR_TRACE_CTL);
  assign hit_buf  = (reg_addr[15:TRACE_BUF_AW] == ADDR_TRACE_BUF[15:TRACE_BUF_AW]);
  assign rd_mux = hit_ctl  ? (path_ctl_reg & PATH_CTL_RW_MASK) :
                  hit_tval ? trace_val_reg :
                  hit_lval ? label_val_reg :
                  hit_tctl ? (trace_ctl_reg & TRACE_CTL_RW_MASK) :
                  hit_buf  ? trace_buf[reg_addr[TRACE_BUF_AW-1:0]] : BYTE_ZERO;

  // The trace value has no defined reset content; it is cleared only for tidiness.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      path_ctl_reg  <= PATH_CTL_RESET;
      trace_val_reg <= TRACE_VAL_RESET;
      label_val_reg <= LABEL_VAL_RESET;
      trace_ctl_reg <= TRACE_CTL_RESET;
      rdata_reg     <= BYTE_ZERO;
    end else begin
      if (reg_write && hit_ctl) begin
        path_ctl_reg <= reg_wdata & PATH_CTL_RW_MASK;
      end
      if (reg_write && hit_tval) begin
        trace_val_reg <= reg_wdata;
      end
      if (reg_write && hit_lval) begin
        label_val_reg <= reg_wdata;
      end
      if (reg_write && hit_tctl) begin
        trace_ctl_reg <= reg_wdata & TRACE_CTL_RW_MASK;
      end
      if (reg_read) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Message storage holds data only, so it carries no reset.
  generate
    for (genvar i = 0; i < TRACE_BUF_DEPTH; i++) begin : g_buf
      always_ff @(posedge clk_sys) begin
        if (reg_write && hit_buf && reg_addr[TRACE_BUF_AW-1:0] == TRACE_BUF_AW'(i)) begin
          trace_buf[i] <= reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_reg     <= '0;
      bclk_reg    <= 1'b0;
      rise_d1_reg <= 1'b0;
      rise_d2_reg <= 1'b0;
      ser_s1_reg  <= 1'b0;
      ser_s2_reg  <= 1'b0;
      cap_d_reg   <= 1'b0;
    end else begin
      div_reg     <= div_next;
      bclk_reg    <= (div_next < DIV_HALF);
      rise_d1_reg <= rise_evt;
      rise_d2_reg <= rise_d1_reg;
      ser_s1_reg  <= overhead_serial_in;
      ser_s2_reg  <= ser_s1_reg;
      cap_d_reg   <= cap_evt;
    end
  end

  // Marker and slot-valid change on the falling edge so the far end sees them settled.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pos_reg    <= POS_LAST;
      slot_reg   <= 1'b0;
      marker_reg <= 1'b0;
      insert_reg <= 1'b0;
    end else begin
      insert_reg <= (trace_src == TPO_SRC_SERIAL) || label_src_serial;
      if (fall_evt) begin
        pos_reg    <= pos_next;
        marker_reg <= (pos_next == '0);
        slot_reg   <= (pos_next <= PW'(C2_LAST_POS));
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      j1_serial_reg <= BYTE_ZERO;
      c2_serial_reg <= BYTE_ZERO;
      msg_idx_reg   <= '0;
      strobe_reg    <= 1'b0;
      trace_out_reg <= BYTE_ZERO;
      label_out_reg <= BYTE_ZERO;
    end else begin
      strobe_reg <= env_evt;
      if (cap_d_reg && pos_reg == PW'(J1_LAST_POS)) begin
        j1_serial_reg <= shift_byte;
      end
      if (cap_d_reg && pos_reg == PW'(C2_LAST_POS)) begin
        c2_serial_reg <= shift_byte;
      end
      if (env_evt) begin
        trace_out_reg <= j1_sel;
        label_out_reg <= c2_sel;
        msg_idx_reg   <= (trace_src == TPO_SRC_BUFFER) ? msg_idx_next : '0;
      end
    end
  end

  assign reg_rdata               = rdata_reg;
  assign overhead_bit_clock      = bclk_reg;
  assign overhead_slot_valid     = slot_reg;
  assign overhead_frame_marker   = marker_reg;
  assign overhead_insert_request = insert_reg;
  assign envelope_strobe         = strobe_reg;
  assign trace_byte_out          = trace_out_reg;
  assign signal_label_out        = label_out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  j1_zero_a: assert property (strobe_reg && $past(trace_src) == TPO_SRC_ZERO
    |-> trace_out_reg == BYTE_ZERO) else $error("J1 not forced to zero");
  j1_buffer_a: assert property (strobe_reg && $past(trace_src) == TPO_SRC_BUFFER
    |-> trace_out_reg == $past(buf_rd)) else $error("J1 not taken from buffer");
  j1_value_a: assert property (strobe_reg && $past(trace_src) == TPO_SRC_VALUE
    |-> trace_out_reg == $past(trace_val_reg)) else $error("J1 not taken from register");
  j1_serial_a: assert property (strobe_reg && $past(trace_src) == TPO_SRC_SERIAL
    |-> trace_out_reg == $past(j1_serial_reg)) else $error("J1 not taken from serial");
  c2_value_a: assert property (strobe_reg && !$past(label_src_serial)
    |-> label_out_reg == $past(label_val_reg)) else $error("C2 not taken from register");
  capture_time_a: assert property (rise_evt |-> ##2 cap_evt && $rose(bclk_reg) == 1'b0
    && bclk_reg) else $error("Serial capture not two cycles after bit clock rise");
  tval_write_a: assert property (reg_write && hit_tval
    |=> trace_val_reg == $past(reg_wdata)) else $error("Trace value write lost");
  lval_write_a: assert property (reg_write && hit_lval
    |=> label_val_reg == $past(reg_wdata)) else $error("Label value write lost");
  ctl_unused_a: assert property (reg_read && hit_ctl
    |=> reg_rdata[1] == 1'b0) else $error("Path control unused bit not zero");
  tctl_upper_a: assert property (reg_read && hit_tctl
    |=> reg_rdata[7:4] == 4'h0) else $error("Trace control upper bits not zero");
  msg_wrap_a: assert property (strobe_reg && $past(msg_size) == 2'h0
    |-> msg_idx_reg == '0) else $error("Single byte message index moved");
  j1_latch_a: assert property (cap_d_reg && pos_reg == PW'(J1_LAST_POS)
    |=> j1_serial_reg == $past(shift_byte)) else $error("Serial J1 byte not held");

  serial_frame_c: cover property (strobe_reg && trace_src == TPO_SRC_SERIAL);
  buffer_frame_c: cover property (strobe_reg && trace_src == TPO_SRC_BUFFER
    && msg_idx_reg == TRACE_BUF_AW'(MSG_LEN_MID - 1));
  c2_serial_c:    cover property (strobe_reg && label_src_serial);

endmodule

// >>> common/tpo_pkg.sv
package tpo_pkg;

  // Register map.
  localparam logic [15:0] ADDR_PATH_CTL   = 16'h1983;
  localparam logic [15:0] ADDR_TRACE_VAL  = 16'h1993;
  localparam logic [15:0] ADDR_LABEL_VAL  = 16'h199f;
  localparam logic [15:0] ADDR_TRACE_CTL  = 16'h19bb;
  localparam logic [15:0] ADDR_TRACE_BUF  = 16'h1d00;
  localparam int          TRACE_BUF_DEPTH = 64;
  localparam int          TRACE_BUF_AW    = 6;

  // Field positions.
  localparam int CTL_LABEL_SRC_BIT = 2;
  localparam int TCTL_SRC_LSB      = 0;
  localparam int TCTL_LEN_LSB      = 2;

  // Reset values and writable masks.
  localparam logic [7:0] PATH_CTL_RESET   = 8'h00;
  localparam logic [7:0] TRACE_VAL_RESET  = 8'h00;
  localparam logic [7:0] LABEL_VAL_RESET  = 8'h00;
  localparam logic [7:0] TRACE_CTL_RESET  = 8'h00;
  localparam logic [7:0] PATH_CTL_RW_MASK = 8'hfd;
  localparam logic [7:0] TRACE_CTL_RW_MASK = 8'h0f;
  localparam logic [7:0] BYTE_ZERO        = 8'h00;

  // Trace message lengths in bytes.
  localparam int MSG_LEN_SHORT = 1;
  localparam int MSG_LEN_MID   = 16;
  localparam int MSG_LEN_LONG  = 64;

  // Serial port timing.
  localparam int CLK_PERIOD_NS     = 10;
  localparam int BIT_CLK_PERIOD_NS = 80;
  localparam int BIT_CLK_DIV       = BIT_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int J1_FIRST_POS      = 1;
  localparam int BYTE_BITS         = 8;
  localparam int J1_LAST_POS       = J1_FIRST_POS + BYTE_BITS - 1;
  localparam int C2_WAIT_PERIODS   = 16;
  localparam int C2_FIRST_POS      = J1_FIRST_POS + C2_WAIT_PERIODS;
  localparam int C2_LAST_POS       = C2_FIRST_POS + BYTE_BITS - 1;

  typedef enum logic [1:0] {
    TPO_SRC_ZERO,
    TPO_SRC_BUFFER,
    TPO_SRC_VALUE,
    TPO_SRC_SERIAL
  } tpo_trace_src_type;

endpackage

// >>> hdl/tpo_shift_in.sv
`timescale 1ns/1ps
module tpo_shift_in
  import tpo_pkg::*;
#(
  parameter int WIDTH = BYTE_BITS
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             shift_en,
  input  wire logic             bit_in,
  output logic      [WIDTH-1:0] data_out
);

  generate
    if (WIDTH < 2) begin : g_bad
      $error("tpo_shift_in: width must be at least two bits");
    end
  endgenerate

  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] data_next;

  // Earlier bits move up, so the first bit ends as the most significant.
  assign data_next = shift_en ? {data_reg[WIDTH-2:0], bit_in} : data_reg;
  assign data_out  = data_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_reg <= '0;
    end else begin
      data_reg <= data_next;
    end
  end

endmodule

// >>> verification/tpo_far_logic.sv
`timescale 1ns/1ps
// Far-end insertion logic: waits for the frame marker, then serialises J1 and C2 MSB first.
module tpo_far_logic (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       bit_clock,
  input  wire logic       slot_valid,
  input  wire logic       frame_marker,
  input  wire logic [7:0] j1_byte,
  input  wire logic [7:0] c2_byte,
  output logic            serial_out
);
  logic       clk_d_reg;
  logic [7:0] pos_reg;
  wire        rise     = bit_clock & ~clk_d_reg;
  wire        fall     = ~bit_clock & clk_d_reg;
  wire  [7:0] pos_next = (pos_reg == 8'hff) ? pos_reg : pos_reg + 8'h01;
  wire  [7:0] j1_idx   = 8'h08 - pos_next;
  wire  [7:0] c2_idx   = 8'h18 - pos_next;
  wire        in_j1    = (pos_next >= 8'h01) && (pos_next <= 8'h08);
  wire        in_c2    = (pos_next >= 8'h11) && (pos_next <= 8'h18);

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_d_reg  <= 1'b0;
      pos_reg    <= 8'hff;
      serial_out <= 1'b0;
    end else begin
      clk_d_reg <= bit_clock;
      if (rise && slot_valid && frame_marker) begin
        pos_reg <= 8'h00;
      end else if (fall) begin
        pos_reg <= pos_next;
        if (in_j1) begin
          serial_out <= j1_byte[j1_idx[2:0]];
        end else if (in_c2) begin
          serial_out <= c2_byte[c2_idx[2:0]];
        end else begin
          // Outside the windows the pin toggles, so a stale bit never matches by luck.
          serial_out <= ~serial_out;
        end
      end
    end
  end
endmodule

// >>> verification/tb_tpo_tx_path_overhead.sv
`timescale 1ns/1ps
module tb_tpo_tx_path_overhead;
  import tpo_pkg::*;
  logic        clk_sys   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [15:0] reg_addr  = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  far_j1    = 8'h00;
  logic [7:0]  far_c2    = 8'h00;
  logic [7:0]  reg_rdata, trace_byte_out, signal_label_out;
  logic        bclk, slot, mark, ins_req, ser, envelope_strobe;
  logic        rd_seen   = 1'b0;
  logic [15:0] lfsr      = 16'hdfec;
  logic [7:0]  rd_q[$];
  logic [15:0] env_q[$];
  logic [7:0]  buf_mem[64];
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  tpo_tx_path_overhead u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .overhead_bit_clock(bclk), .overhead_slot_valid(slot), .overhead_frame_marker(mark),
    .overhead_insert_request(ins_req), .overhead_serial_in(ser),
    .envelope_strobe(envelope_strobe), .trace_byte_out(trace_byte_out),
    .signal_label_out(signal_label_out));
  tpo_far_logic u_far (.clk_sys(clk_sys), .reset_n(reset_n), .bit_clock(bclk),
    .slot_valid(slot), .frame_marker(mark), .j1_byte(far_j1), .c2_byte(far_c2),
    .serial_out(ser));

  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (exp !== got) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
  endtask
  task automatic wait_env();
    for (int i = 0; i < 20000 && env_q.size() != 0; i++) @(posedge clk_sys);
    if (env_q.size() != 0) begin
      check("envelope wait", 16'h0000, 16'h0001);
      env_q.delete();
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (rd_seen && rd_q.size() != 0) check("reg_rdata", {8'h00, rd_q.pop_front()}, {8'h00, reg_rdata});
    if (envelope_strobe === 1'b1 && env_q.size() != 0) check("envelope", env_q.pop_front(), {trace_byte_out, signal_label_out});
    rd_seen <= reg_read;
  end

  initial begin
    // About one and a half times the longest expected run.
    #700_000;
    error_cnt++;
    summarize();
  end

  initial begin
    logic [7:0] t, l, s, b, j1e;
    logic [1:0] src;
    int         k, len;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    reg_rd(ADDR_PATH_CTL, 8'h00);
    reg_rd(ADDR_LABEL_VAL, 8'h00);
    reg_rd(ADDR_TRACE_CTL, TRACE_CTL_RESET);
    reg_wr(ADDR_PATH_CTL, 8'hff);
    reg_rd(ADDR_PATH_CTL, 8'hfd);
    reg_wr(ADDR_TRACE_CTL, 8'hff);
    reg_rd(ADDR_TRACE_CTL, 8'h0f);
    reg_wr(16'h1234, 8'h5a);
    reg_rd(16'h1234, 8'h00);
    for (int i = 0; i < 64; i++) begin
      buf_mem[i] = 8'h80 + i[7:0];
      reg_wr(ADDR_TRACE_BUF + i[15:0], buf_mem[i]);
    end
    $display("test registers done");
    // Mode 4 runs both bytes from the serial pin at once.
    for (int m = 0; m < 5; m++) begin
      t = rnd();
      l = rnd();
      s = rnd();
      b = rnd();
      src = (m == 4) ? 2'b11 : m[1:0];
      far_j1 <= s;
      far_c2 <= b;
      reg_wr(ADDR_TRACE_VAL, t);
      reg_rd(ADDR_TRACE_VAL, t);
      reg_wr(ADDR_LABEL_VAL, l);
      reg_rd(ADDR_LABEL_VAL, l);
      reg_wr(ADDR_TRACE_CTL, {6'h00, src});
      reg_wr(ADDR_PATH_CTL, {5'h00, m == 4, 2'b00});
      j1e = (src == 2'b00) ? 8'h00 : (src == 2'b01) ? buf_mem[0] : (src == 2'b10) ? t : s;
      repeat (2) @(posedge clk_sys iff envelope_strobe);
      // Step past the strobe so the watcher cannot pair it with the new notes.
      @(posedge clk_sys);
      check("insert request", {15'h0, src == 2'b11 || m == 4}, {15'h0, ins_req});
      env_q.push_back({j1e, (m == 4) ? b : l});
      env_q.push_back({j1e, (m == 4) ? b : l});
      wait_env();
      $display("test source mode %0d done", m);
    end
    reg_wr(ADDR_PATH_CTL, 8'h00);
    for (int z = 1; z < 4; z++) begin
      len = (z == 1) ? MSG_LEN_MID : MSG_LEN_LONG;
      reg_wr(ADDR_TRACE_CTL, {4'h0, z[1:0], 2'b01});
      repeat (3) @(posedge clk_sys iff envelope_strobe);
      @(posedge clk_sys);
      // The buffer phase is picked up once; the next len envelopes, one full message, must follow it.
      k = int'(trace_byte_out - 8'h80);
      for (int n = 1; n <= len; n++) env_q.push_back({buf_mem[(k + n) % len], l});
      wait_env();
      $display("test message size %0d done", z);
    end
    summarize();
  end
endmodule
